// ---- core/vtlb_limiter.sv ----
`timescale 1ns/1ps
`include "vtlb_params.svh"
// Functional notes
// [R1] Ceiling threshold code means 2 V plus 0.1 V per code.
// [R2] Floor threshold code means 2 V plus 0.1 V per code, reset 0x1E.
// [R3] Knee voltage code means 2 V plus 0.1 V per code, reset 0x58.
// [R4] Below the knee, threshold drops by slope times battery shortfall.
// [R5] Slope codes select 1, 1.5, 2 or 4 V/V, reset 1 V/V.
// [R6] Tracked threshold never falls below the floor threshold.
// [R7] Software sets floor below lowest battery for an unclamped track.
// [R8] Battery below brownout threshold starts attack within 10 us.
// [R9] Brownout prevention follows its enable bit, reset enabled.
// [R10] Brownout prevention runs even with the limiter disabled.
// [R11] Brownout threshold is 4.5 V plus 25 mV per code, reset 5.0 V.
// [R12] Brownout attack interval is 5 us doubled per code.
// [R13] Brownout step is 0.5, 1, 1.5 or 2 dB, reset 1 dB.
// [R14] Brownout hold is 0 to 1000 ms by table, reset 500 ms.
// [R15] Brownout has own attack and hold, releases at limiter rate.
// [R16] Shutdown-on-brownout shuts down until a shutdown state passes.
// [R17] Infinite hold keeps hold until mute, shutdown or hold clear.
// [R18] Hold clear write starts release and always reads zero.
// [R19] Limiter attacks while signal level exceeds effective threshold.
// [R20] Limiter and brownout share one maximum attenuation budget.
// [R21] Limiter runs only with its enable bit set, reset disabled.
// [R22] Release interval codes give 10 to 1500 ms, reset 1000 ms.
// [R23] Each attack interval removes one step while the cause persists.
// [R24] Battery measurement is same-clock and in threshold units.
module vtlb_limiter
   import vtlb_pkg::*;
#(
   parameter int US_PER_MS = 1000,
   parameter int LIM_ATK_US = 20,
   parameter int LIM_HOLD_MS = 500,
   parameter logic [7:0] LIM_STEP = 8'h02,
   parameter logic [7:0] RLS_STEP = 8'h02
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [9:0] vbat_i,
   input wire logic [9:0] level_i,
   input wire logic mute_i,
   input wire logic sw_shutdown_i,
   output logic [7:0] atten_o,
   output logic [9:0] eff_thresh_o,
   output logic brownout_o,
   output logic hold_o,
   output logic shutdown_o
);
   // ****************************************************
   // Elaboration checks
   // ****************************************************
   localparam int TICK_CYC = `VTLB_CLK_MHZ * `VTLB_TICK_US;
   localparam int LAT_CYC = `VTLB_CLK_MHZ * `VTLB_BOP_LAT_US;
   // Timer holds at most 1500 ms worth of microseconds
   if (US_PER_MS < 1 || US_PER_MS > 1000) begin : g_chk_ms
      $error("US_PER_MS out of range");
   end
   if (LIM_ATK_US < 1 || LIM_ATK_US > 1000 || LIM_HOLD_MS > 1000) begin : g_chk_lim
      $error("limiter timing out of range");
   end
   if (LAT_CYC <= TICK_CYC) begin : g_chk_lat
      $error("tick too slow for brownout latency");
   end

   // ****************************************************
   // Functions
   // ****************************************************
   // Table codes of hold time in ms
   function automatic logic [10:0] hold_ms(input logic [2:0] c);
      unique case (c)
         3'h0: hold_ms = 11'h000;
         3'h1: hold_ms = 11'h00A;
         3'h2: hold_ms = 11'h019;
         3'h3: hold_ms = 11'h032;
         3'h4: hold_ms = 11'h064;
         3'h5: hold_ms = 11'h0FA;
         3'h6: hold_ms = 11'h1F4;
         3'h7: hold_ms = 11'h3E8;
      endcase
   endfunction

   // Table codes of release interval in ms
   function automatic logic [10:0] rls_ms(input logic [2:0] c);
      unique case (c)
         3'h0: rls_ms = 11'h00A;
         3'h1: rls_ms = 11'h032;
         3'h2: rls_ms = 11'h064;
         3'h3: rls_ms = 11'h0FA;
         3'h4: rls_ms = 11'h1F4;
         3'h5: rls_ms = 11'h2EE;
         3'h6: rls_ms = 11'h3E8;
         3'h7: rls_ms = 11'h5DC;
      endcase
   endfunction

   // Milliseconds to microsecond ticks
   function automatic logic [20:0] ms_to_us(input logic [10:0] ms);
      logic [31:0] p;
      p = 32'(ms) * 32'(US_PER_MS);
      ms_to_us = p[20:0];
   endfunction

   // Limiter-scale code to 25 mV units
   function automatic logic [9:0] lim_volt(input logic [6:0] c);
      lim_volt = `VTLB_LIM_BASE + {1'b0, c, 2'b00}; // [R1] [R2] [R3]
   endfunction

   // Attenuation plus step, capped by budget
   function automatic logic [7:0] add_cap(input logic [7:0] a, input logic [7:0] s,
                                          input logic [7:0] cap);
      logic [8:0] sum;
      sum = {1'b0, a} + {1'b0, s};
      if (a >= cap) begin
         add_cap = a;
      end else if (sum > {1'b0, cap}) begin
         add_cap = cap;
      end else begin
         add_cap = sum[7:0];
      end
   endfunction

   // ****************************************************
   // Registers
   // ****************************************************
   logic limiter_enable_ff, brownout_enable_ff, shut_en_ff, inf_hold_ff;
   logic [1:0] slope_ff;
   logic [6:0] ceil_ff, floor_ff, knee_ff;
   logic [2:0] rls_ff;
   logic [4:0] budget_ff;
   logic [7:0] brownout_threshold_ff;
   logic [2:0] bop_rate_ff, bop_hold_ff;
   logic [1:0] bop_step_ff;
   logic hold_clr;
   vtlb_state_type state_ff;
   logic src_bop_ff;
   logic [7:0] atten_ff;
   logic [9:0] eff_th_ff;

   assign hold_clr = wr_i && addr_i == `VTLB_OFS_CTRL && wdata_i[`VTLB_B_HCLR]; // [R18]

   // Control register writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         limiter_enable_ff <= 1'b0; // [R21]
         brownout_enable_ff <= 1'b1; // [R9]
         shut_en_ff <= 1'b0;
         inf_hold_ff <= 1'b0;
         slope_ff <= `VTLB_RST_SLOPE; // [R5]
      end else if (wr_i && addr_i == `VTLB_OFS_CTRL) begin
         limiter_enable_ff <= wdata_i[`VTLB_B_LIMITER_ENABLE]; // [R21]
         brownout_enable_ff <= wdata_i[`VTLB_B_BROWNOUT_ENABLE]; // [R9]
         shut_en_ff <= wdata_i[`VTLB_B_SHUT];
         inf_hold_ff <= wdata_i[`VTLB_B_INFH];
         slope_ff <= wdata_i[`VTLB_B_SLOPE +: 2];
      end
   end

   // Limiter threshold register writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ceil_ff <= `VTLB_RST_CEIL;
         floor_ff <= `VTLB_RST_FLOOR; // [R2]
         knee_ff <= `VTLB_RST_KNEE; // [R3]
         rls_ff <= `VTLB_RST_RLS; // [R22]
         budget_ff <= `VTLB_RST_BUDGET;
      end else if (wr_i && addr_i == `VTLB_OFS_LIM) begin
         ceil_ff <= wdata_i[`VTLB_B_CEIL +: 7];
         floor_ff <= wdata_i[`VTLB_B_FLOOR +: 7];
         knee_ff <= wdata_i[`VTLB_B_KNEE +: 7];
         rls_ff <= wdata_i[`VTLB_B_RLS +: 3];
         budget_ff <= wdata_i[`VTLB_B_BUDGET +: 5];
      end
   end

   // Brownout register writes
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         brownout_threshold_ff <= `VTLB_RST_BTH; // [R11]
         bop_rate_ff <= `VTLB_RST_BRATE; // [R12]
         bop_step_ff <= `VTLB_RST_BSTEP; // [R13]
         bop_hold_ff <= `VTLB_RST_BHOLD; // [R14]
      end else if (wr_i && addr_i == `VTLB_OFS_BOP) begin
         brownout_threshold_ff <= wdata_i[`VTLB_B_BTH +: 8];
         bop_rate_ff <= wdata_i[`VTLB_B_BRATE +: 3];
         bop_step_ff <= wdata_i[`VTLB_B_BSTEP +: 2];
         bop_hold_ff <= wdata_i[`VTLB_B_BHOLD +: 3];
      end
   end

   // Read data, one cycle after the strobe; hold clear reads zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         unique case (addr_i)
            `VTLB_OFS_CTRL: rdata_o <= {25'h0, slope_ff, 1'b0, inf_hold_ff,
                                        shut_en_ff, brownout_enable_ff, limiter_enable_ff}; // [R18]
            `VTLB_OFS_LIM: rdata_o <= {budget_ff, rls_ff, 1'b0, knee_ff, 1'b0,
                                       floor_ff, 1'b0, ceil_ff};
            `VTLB_OFS_BOP: rdata_o <= {13'h0, bop_hold_ff, 2'h0, bop_step_ff, 1'b0,
                                       bop_rate_ff, brownout_threshold_ff};
            `VTLB_OFS_STAT: rdata_o <= {eff_th_ff, state_ff, src_bop_ff, 7'h00, atten_ff};
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // ****************************************************
   // Battery tracked threshold
   // ****************************************************
   logic [9:0] ceil_v, floor_v, knee_v, short_v;
   logic [12:0] red_v;
   logic [9:0] nxt_eff_th;

   // Battery word already in 25 mV units on this clock; no synchroniser needed
   always_comb begin
      ceil_v = lim_volt(ceil_ff);
      floor_v = lim_volt(floor_ff);
      knee_v = lim_volt(knee_ff);
      short_v = (vbat_i < knee_v) ? knee_v - vbat_i : 10'h000; // [R4] [R24]
      unique case (slope_ff)
         2'h0: red_v = {3'h0, short_v}; // [R5]
         2'h1: red_v = {3'h0, short_v} + {4'h0, short_v[9:1]};
         2'h2: red_v = {2'h0, short_v, 1'b0};
         2'h3: red_v = {1'b0, short_v, 2'b00};
      endcase
      if (red_v == 13'h0000) begin
         nxt_eff_th = ceil_v; // Fixed threshold; floor plays no part
      end else if (red_v >= {3'h0, ceil_v} || ceil_v - red_v[9:0] < floor_v) begin
         nxt_eff_th = floor_v; // [R6] [R7]
      end else begin
         nxt_eff_th = ceil_v - red_v[9:0]; // [R4]
      end
   end

   // Registered threshold for the compare and the output
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         eff_th_ff <= 10'h000;
      end else begin
         eff_th_ff <= nxt_eff_th;
      end
   end

   // ****************************************************
   // Microsecond tick and interval timer
   // ****************************************************
   logic [7:0] div_ff;
   logic us_tick;
   logic [20:0] timer_ff;

   assign us_tick = (div_ff == 8'(TICK_CYC - 1));

   // One-cycle enable every microsecond
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_ff <= 8'h00;
      end else if (us_tick) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // ****************************************************
   // Gain engine
   // ****************************************************
   logic bop_low, lim_over, cause;
   logic [7:0] budget_q, bop_step_q, step_q;
   logic [20:0] atk_us, hold_us, rls_us;

   always_comb begin
      bop_low = brownout_enable_ff && ({2'b00, brownout_threshold_ff} + `VTLB_BOP_BASE) > vbat_i; // [R8] [R10] [R11]
      lim_over = limiter_enable_ff && level_i > eff_th_ff; // [R19] [R21]
      cause = bop_low || lim_over;
      budget_q = 8'h04 + {2'h0, budget_ff, 1'b0}; // [R20] 1 dB + 0.5 dB per code
      bop_step_q = {5'h00, bop_step_ff, 1'b0} + 8'h02; // [R13] quarter-dB units
      step_q = src_bop_ff ? bop_step_q : LIM_STEP; // [R15]
      atk_us = src_bop_ff ? 21'(`VTLB_BASE_ATK_US) << bop_rate_ff // [R12]
                          : 21'(LIM_ATK_US);
      hold_us = src_bop_ff ? ms_to_us(hold_ms(bop_hold_ff)) // [R14] [R15]
                           : ms_to_us(11'(LIM_HOLD_MS));
      rls_us = ms_to_us(rls_ms(rls_ff)); // [R15] [R22]
   end

   // State, cause, timer and attenuation share one process for step timing
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= VTLB_IDLE;
         src_bop_ff <= 1'b0;
         timer_ff <= 21'h000000;
         atten_ff <= 8'h00;
      end else begin
         if (us_tick && timer_ff != 21'h000000) begin
            timer_ff <= timer_ff - 21'h000001;
         end
         unique case (state_ff)
            VTLB_SHUT: begin
               // Left only through a software shutdown state on sw_shutdown_i
               if (sw_shutdown_i) begin
                  state_ff <= VTLB_IDLE; // [R16]
                  atten_ff <= 8'h00;
               end
            end
            VTLB_ATTACK: begin
               if (bop_low && shut_en_ff) begin
                  state_ff <= VTLB_SHUT; // [R16]
               end else if (bop_low && !src_bop_ff) begin
                  src_bop_ff <= 1'b1; // Brownout takes priority at once
                  timer_ff <= 21'h000000;
               end else if (!cause) begin
                  state_ff <= (src_bop_ff && inf_hold_ff) ? VTLB_INFH : VTLB_HOLD; // [R17]
                  timer_ff <= hold_us;
               end else if (timer_ff == 21'h000000) begin
                  atten_ff <= add_cap(atten_ff, step_q, budget_q); // [R20] [R23]
                  // Full count: the next step lands one cycle after the last tick
                  timer_ff <= atk_us; // [R23]
               end
            end
            VTLB_INFH: begin
               if (cause) begin
                  state_ff <= VTLB_ATTACK;
                  src_bop_ff <= bop_low;
                  timer_ff <= 21'h000000;
               end else if (hold_clr || mute_i || sw_shutdown_i) begin
                  state_ff <= VTLB_RELEASE; // [R17] [R18]
                  timer_ff <= rls_us;
               end
            end
            default: begin
               // Idle, hold and release all restart attack on a new cause
               if (cause) begin
                  state_ff <= VTLB_ATTACK; // [R8] [R10]
                  src_bop_ff <= bop_low;
                  timer_ff <= 21'h000000; // First step next cycle
                  if (bop_low && shut_en_ff) begin
                     state_ff <= VTLB_SHUT; // [R16]
                  end
               end else if (state_ff == VTLB_HOLD && timer_ff == 21'h000000) begin
                  state_ff <= VTLB_RELEASE; // [R15]
                  timer_ff <= rls_us;
               end else if (state_ff == VTLB_RELEASE) begin
                  if (atten_ff == 8'h00) begin
                     state_ff <= VTLB_IDLE;
                     src_bop_ff <= 1'b0;
                  end else if (timer_ff == 21'h000000) begin
                     atten_ff <= (atten_ff > RLS_STEP) ? atten_ff - RLS_STEP : 8'h00;
                     timer_ff <= rls_us; // [R22]
                  end
               end
            end
         endcase
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign atten_o = atten_ff;
   assign eff_thresh_o = eff_th_ff;
   assign brownout_o = src_bop_ff && state_ff == VTLB_ATTACK;
   assign hold_o = state_ff == VTLB_HOLD || state_ff == VTLB_INFH;
   assign shutdown_o = state_ff == VTLB_SHUT;
endmodule // vtlb_limiter

// ---- pkg/vtlb_params.svh ----
`ifndef VTLB_PARAMS_SVH
`define VTLB_PARAMS_SVH
// ****************************************************
// Register offsets (byte addresses)
// ****************************************************
`define VTLB_OFS_CTRL 8'h00
`define VTLB_OFS_LIM 8'h04
`define VTLB_OFS_BOP 8'h08
`define VTLB_OFS_STAT 8'h0C
// ****************************************************
// Field positions
// ****************************************************
`define VTLB_B_LIMITER_ENABLE 0
`define VTLB_B_BROWNOUT_ENABLE 1
`define VTLB_B_SHUT 2
`define VTLB_B_INFH 3
`define VTLB_B_HCLR 4
`define VTLB_B_SLOPE 5
`define VTLB_B_CEIL 0
`define VTLB_B_FLOOR 8
`define VTLB_B_KNEE 16
`define VTLB_B_RLS 24
`define VTLB_B_BUDGET 27
`define VTLB_B_BTH 0
`define VTLB_B_BRATE 8
`define VTLB_B_BSTEP 12
`define VTLB_B_BHOLD 16
// ****************************************************
// Reset values
// ****************************************************
`define VTLB_RST_CEIL 7'h6E
`define VTLB_RST_FLOOR 7'h1E
`define VTLB_RST_KNEE 7'h58
`define VTLB_RST_SLOPE 2'h0
`define VTLB_RST_RLS 3'h6
`define VTLB_RST_BUDGET 5'h10
`define VTLB_RST_BTH 8'h14
`define VTLB_RST_BRATE 3'h2
`define VTLB_RST_BSTEP 2'h1
`define VTLB_RST_BHOLD 3'h6
// ****************************************************
// Voltage scale, 25 mV units
// ****************************************************
`define VTLB_LIM_BASE 10'h050
`define VTLB_BOP_BASE 10'h0B4
// ****************************************************
// Timing
// ****************************************************
`define VTLB_CLK_MHZ 40
`define VTLB_TICK_US 1
`define VTLB_BOP_LAT_US 10
`define VTLB_BASE_ATK_US 5
`endif

// ---- pkg/vtlb_pkg.sv ----
package vtlb_pkg;
   // Gain engine states, one-hot
   typedef enum logic [5:0] {
      VTLB_IDLE = 6'h01,
      VTLB_ATTACK = 6'h02,
      VTLB_HOLD = 6'h04,
      VTLB_INFH = 6'h08,
      VTLB_RELEASE = 6'h10,
      VTLB_SHUT = 6'h20
   } vtlb_state_type;
endpackage

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
`define WT(c, n) begin @(negedge clk_i); for (int k = 0; k < (n) && !(c); k++) @(negedge clk_i); end
module tb_top;
   logic clk_i, rst_i, wr_i, rd_i, mute_i, sw_shutdown_i;
   logic brownout_o, hold_o, shutdown_o;
   logic [7:0] addr_i, atten_o;
   logic [31:0] wdata_i, rdata_o;
   logic [9:0] vbat_i, level_i, eff_thresh_o;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   // Sim scale: ms act as us, short limiter timing
   vtlb_limiter #(.US_PER_MS(1), .LIM_ATK_US(2), .LIM_HOLD_MS(1), .LIM_STEP(8'h02),
      .RLS_STEP(8'h02)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vbat_i(vbat_i),
      .level_i(level_i), .mute_i(mute_i), .sw_shutdown_i(sw_shutdown_i), .atten_o(atten_o),
      .eff_thresh_o(eff_thresh_o), .brownout_o(brownout_o), .hold_o(hold_o),
      .shutdown_o(shutdown_o));
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ****************************************************
   // Helpers
   // ****************************************************
   task conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task rc(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      `CHK(n, e, rdata_o);
   endtask
   task lim(input logic [6:0] c, f, k, input logic [2:0] r, input logic [4:0] b);
      wr(8'h04, {b, r, 1'b0, k, 1'b0, f, 1'b0, c});
   endtask
   // Expected tracked threshold, 25 mV units; slope held in halves
   function int eff(int ce, int fl, int kn, int sl, int vb);
      int r;
      r = (vb < 80 + 4 * kn) ? (80 + 4 * kn - vb) * (sl == 3 ? 8 : sl + 2) / 2 : 0;
      if (r == 0) return 80 + 4 * ce;
      return (80 + 4 * ce - r < 80 + 4 * fl) ? 80 + 4 * fl : 80 + 4 * ce - r;
   endfunction
   // Hang guard, well above the expected run length
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         conclude();
      end
   end
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      rst_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 32'h0000_0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      vbat_i = 10'h1E0;
      level_i = 10'h000;
      mute_i = 1'b0;
      sw_shutdown_i = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rc("ctrl", 8'h00, 32'h0000_0002);
      rc("lim", 8'h04, 32'h8658_1E6E);
      rc("bop", 8'h08, 32'h0006_1214);
      rc("stat", 8'h0C, 32'h8201_0000);
      rc("unmapped", 8'h10, 32'h0000_0000);
      // Tracking below the knee, every slope, with and without floor clamp
      lim(7'h6E, 7'h30, 7'h58, 3'h0, 5'h05);
      for (int s = 0; s < 4; s++) begin
         wr(8'h00, 32'h2 | 32'(s << 5));
         for (int j = 0; j < 2; j++) begin
            @(posedge clk_i) vbat_i <= j ? 10'h0E8 : 10'h188;
            repeat (3) @(negedge clk_i);
            `CHK("eff", eff(7'h6E, 7'h30, 7'h58, s, j ? 10'h0E8 : 10'h188), eff_thresh_o);
         end
      end
      wr(8'h00, 32'h0000_0002);
      lim(7'h7F, 7'h00, 7'h58, 3'h0, 5'h05);
      @(posedge clk_i) vbat_i <= 10'h1E0;
      repeat (3) @(negedge clk_i);
      `CHK("eff_top", 10'h24C, eff_thresh_o);
      // Floor under every battery level used here: tracking runs unclamped
      @(posedge clk_i) vbat_i <= 10'h0E8;
      repeat (3) @(negedge clk_i);
      `CHK("eff_nofloor", 10'h184, eff_thresh_o);
      // Brownout: 5 us attack, 2 dB step, 10 us hold, cap 14 quarter-dB
      lim(7'h6E, 7'h30, 7'h58, 3'h0, 5'h05);
      wr(8'h08, {13'h0000, 3'h1, 2'h0, 2'h3, 1'b0, 3'h0, 8'h14});
      @(posedge clk_i) vbat_i <= 10'h0C7;
      `WT(brownout_o, 4)
      `CHK("bop_flag", 1'b1, brownout_o);
      `WT(atten_o == 8'h08, 400)
      `CHK("bop_step", 8'h08, atten_o);
      // Next step not within 150 cycles (3.75 us) of the first
      repeat (150) @(negedge clk_i);
      `CHK("bop_rate", 8'h08, atten_o);
      `WT(atten_o != 8'h08, 220)
      `CHK("bop_cap", 8'h0E, atten_o);
      @(posedge clk_i) vbat_i <= 10'h1E0;
      `WT(hold_o, 4)
      repeat (300) @(negedge clk_i);
      `CHK("hold_gain", 8'h0E, atten_o);
      `WT(!hold_o, 200)
      `CHK("hold_end", 1'b0, hold_o);
      `WT(atten_o == 8'h0C, 500)
      `CHK("rls_step", 8'h0C, atten_o);
      `WT(atten_o == 8'h00, 3000)
      `CHK("rls_done", 8'h00, atten_o);
      // Brownout disabled ignores a deep dip
      wr(8'h00, 32'h0000_0000);
      @(posedge clk_i) vbat_i <= 10'h096;
      repeat (300) @(negedge clk_i);
      `CHK("bop_off", 8'h00, atten_o);
      // Infinite hold, left by hold clear then by mute
      for (int e = 0; e < 2; e++) begin
         wr(8'h00, 32'h0000_000A);
         @(posedge clk_i) vbat_i <= 10'h0C7;
         repeat (300) @(negedge clk_i);
         @(posedge clk_i) vbat_i <= 10'h1E0;
         repeat (1500) @(negedge clk_i);
         `CHK("inf_hold", 1'b1, hold_o);
         if (e == 0) begin
            wr(8'h00, 32'h0000_001A);
            rc("hclr_rd", 8'h00, 32'h0000_000A);
         end else begin
            @(posedge clk_i) mute_i <= 1'b1;
         end
         `WT(!hold_o, 5)
         `CHK("inf_exit", 1'b0, hold_o);
         @(posedge clk_i) mute_i <= 1'b0;
         `WT(atten_o == 8'h00, 3500)
         `CHK("inf_rls", 8'h00, atten_o);
      end
      // Shutdown on brownout needs a shutdown state to leave
      wr(8'h00, 32'h0000_0006);
      @(posedge clk_i) vbat_i <= 10'h0C7;
      `WT(shutdown_o, 4)
      @(posedge clk_i) vbat_i <= 10'h1E0;
      repeat (1000) @(negedge clk_i);
      `CHK("shut_kept", 1'b1, shutdown_o);
      @(posedge clk_i) sw_shutdown_i <= 1'b1;
      repeat (3) @(negedge clk_i);
      `CHK("shut_exit", 1'b0, shutdown_o);
      @(posedge clk_i) sw_shutdown_i <= 1'b0;
      // Limiter off, then on with signal above the threshold
      wr(8'h00, 32'h0000_0000);
      @(posedge clk_i) level_i <= 10'h258;
      repeat (200) @(negedge clk_i);
      `CHK("lim_off", 8'h00, atten_o);
      wr(8'h00, 32'h0000_0001);
      `WT(atten_o == 8'h02, 200)
      `CHK("lim_step", 8'h02, atten_o);
      repeat (700) @(negedge clk_i);
      `CHK("lim_cap", 8'h0E, atten_o);
      @(posedge clk_i) level_i <= 10'h000;
      `WT(atten_o == 8'h00, 3500)
      `CHK("lim_rls", 8'h00, atten_o);
      conclude();
   end
endmodule // tb_top
bind vtlb_limiter vtlb_limiter_props i_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vbat_i(vbat_i),
   .mute_i(mute_i), .sw_shutdown_i(sw_shutdown_i), .atten_o(atten_o),
   .brownout_o(brownout_o), .hold_o(hold_o), .shutdown_o(shutdown_o));

// ---- verif/vtlb_limiter_props.sv ----
`timescale 1ns/1ps
`include "vtlb_params.svh"
// ****************************************************
// Port checker for the limiter and brownout engine
// ****************************************************
module vtlb_limiter_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [9:0] vbat_i,
   input wire logic mute_i,
   input wire logic sw_shutdown_i,
   input wire logic [7:0] atten_o,
   input wire logic brownout_o,
   input wire logic hold_o,
   input wire logic shutdown_o
);
   logic brownout_enable_ff;
   logic [7:0] brownout_threshold_ff;
   logic [4:0] budget_ff;
   logic bop_cause;
   // Shadow of only the fields the properties need
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         brownout_enable_ff <= 1'b1;
         brownout_threshold_ff <= `VTLB_RST_BTH;
         budget_ff <= `VTLB_RST_BUDGET;
      end else if (wr_i) begin
         if (addr_i == `VTLB_OFS_CTRL) brownout_enable_ff <= wdata_i[`VTLB_B_BROWNOUT_ENABLE];
         if (addr_i == `VTLB_OFS_BOP) brownout_threshold_ff <= wdata_i[`VTLB_B_BTH +: 8];
         if (addr_i == `VTLB_OFS_LIM) budget_ff <= wdata_i[`VTLB_B_BUDGET +: 5];
      end
   end
   // Mute and shutdown excluded, they take the engine elsewhere
   assign bop_cause = brownout_enable_ff && !mute_i && !sw_shutdown_i
      && ({2'b00, vbat_i} < `VTLB_BOP_BASE + {4'h0, brownout_threshold_ff});
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_bop_fast_attack: assert property (
      bop_cause |-> ##[1:2] (brownout_o || shutdown_o)) else $error("brownout attack late");
   a_atten_budget_cap: assert property (
      int'(atten_o) <= 4 + 2 * int'(budget_ff)) else $error("attenuation above budget");
   a_atten_step_size: assert property (
      int'(atten_o) <= int'($past(atten_o)) + 8) else $error("attenuation step too big");
   a_hold_gain_flat: assert property (
      hold_o && $past(hold_o) && !$past(mute_i) && !$past(sw_shutdown_i) |-> $stable(atten_o))
      else $error("gain moved during hold");
   a_shut_stays_on: assert property (
      shutdown_o && !sw_shutdown_i |=> shutdown_o) else $error("shutdown left early");
   a_shut_exit: assert property (
      shutdown_o && sw_shutdown_i |-> ##[1:2] !shutdown_o) else $error("shutdown not left");
   a_flags_exclusive: assert property (
      $onehot0({brownout_o, hold_o, shutdown_o})) else $error("state flags overlap");
   a_rdata_idle_zero: assert property (
      !$past(rd_i) |-> rdata_o == 32'h0000_0000) else $error("read data outside slot");
   a_hclr_reads_zero: assert property (
      $past(rd_i) && $past(addr_i) == `VTLB_OFS_CTRL |-> !rdata_o[`VTLB_B_HCLR])
      else $error("hold clear read back high");
   // Main scenarios reached
   c_bop_rise: cover property ($rose(brownout_o));
   c_hold_exit: cover property ($fell(hold_o));
   c_shut_rise: cover property ($rose(shutdown_o));
endmodule // vtlb_limiter_props
